// ---- fmpt_pkg.sv ----
// fmpt_pkg: constants for the flash map / protect / trigger block
// assumes a 24-bit byte address space and a 16-bit data bus
package fmpt_pkg;

  // ---------------------------------------------------------------
  // register map (apb byte offsets)
  // ---------------------------------------------------------------
  localparam logic [11:0] FMPT_OFF_SYSCFG  = 12'h000;
  localparam logic [11:0] FMPT_OFF_CMD     = 12'h004;
  localparam logic [11:0] FMPT_OFF_STATUS  = 12'h008;
  localparam logic [11:0] FMPT_OFF_RESULT  = 12'h00c;
  localparam logic [11:0] FMPT_OFF_DONE    = 12'h010;

  // ---------------------------------------------------------------
  // system config fields
  // ---------------------------------------------------------------
  localparam int FMPT_BIT_FLASH_EN  = 0;
  localparam int FMPT_BIT_REMAP     = 1;
  localparam int FMPT_BIT_SEGDIS    = 2;
  localparam int FMPT_BIT_END_OF_INIT_INSTR     = 3;
  localparam logic FMPT_REMAP_RST   = 1'b0;
  localparam logic FMPT_SEGDIS_RST  = 1'b1;

  // ---------------------------------------------------------------
  // commands and codes
  // ---------------------------------------------------------------
  localparam logic [11:0] FMPT_CMD_DWORD = 12'hdd4;
  localparam logic [11:0] FMPT_CMD_BLOCK = 12'haa5;
  localparam logic [15:0] FMPT_DUMMY     = 16'hb88b;
  localparam logic [7:0]  FMPT_ERR_OK    = 8'h00;
  localparam logic [7:0]  FMPT_ERR_PROT  = 8'h01;

  // ---------------------------------------------------------------
  // address map
  // ---------------------------------------------------------------
  localparam logic [23:0] FMPT_LOW_SEG0  = 24'h000000;
  localparam logic [23:0] FMPT_LOW_SEG1  = 24'h010000;
  localparam logic [23:0] FMPT_LOW_SIZE  = 24'h008000;
  localparam logic [23:0] FMPT_FIX_LO    = 24'h018000;
  localparam logic [23:0] FMPT_FIX_HI    = 24'h04ffff;

  typedef enum logic [1:0] {FMPT_IDLE, FMPT_ARMED, FMPT_RUN} fmpt_trig_t;

endpackage

// ---- fmpt_top.sv ----
// fmpt_top: flash mapping, protection and command trigger
// assumes the core presents one access per cycle with its fetch address
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps

module fmpt_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        external_access_pin,
  input  wire logic        otp_protect_bit,
  input  wire logic        mem_req,
  input  wire logic        mem_write,
  input  wire logic        mem_direct,
  input  wire logic [23:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  input  wire logic [23:0] fetch_addr,
  input  wire logic        segment_override_prefix,
  input  wire logic [15:0] flash_rdata,
  output logic      [15:0] mem_rdata,
  output logic             mem_hit_flash,
  output logic             irq_block,
  output logic             cmd_start,
  output logic      [15:0] cmd_code,
  output logic             protect_active
);
  import fmpt_pkg::*;

  // ---------------------------------------------------------------
  // synchronisers for pins
  // ---------------------------------------------------------------
  logic [1:0] ea_sync_reg;
  logic [1:0] otp_sync_reg;
  logic       strap_done_reg;

  // no reset here: the chain fills while reset is held, so the
  // strap capture right after release sees the real pin levels
  always_ff @(posedge pclk) begin
    ea_sync_reg  <= {ea_sync_reg[0], external_access_pin};
    otp_sync_reg <= {otp_sync_reg[0], otp_protect_bit};
  end

  // ---------------------------------------------------------------
  // configuration state
  // ---------------------------------------------------------------
  logic        flash_enable_bit;
  logic        low_block_remap_bit;
  logic        segmentation_disable_bit;
  logic        end_of_init_instr_done_reg;
  logic [15:0] cmd_reg;
  logic [7:0]  result_reg;
  logic        busy_reg;
  logic        apb_wr;
  logic        apb_rd;
  logic        done_wr;
  logic        strap_cnt_reg;

  assign apb_wr  = psel && penable && pwrite && pready;
  assign apb_rd  = psel && !penable && !pwrite;
  assign done_wr = apb_wr && (paddr == FMPT_OFF_DONE) && busy_reg;

  // strap caught two edges after release, once the synchroniser is full
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt_reg  <= 1'b0;
      strap_done_reg <= 1'b0;
    end else begin
      strap_cnt_reg  <= 1'b1;
      strap_done_reg <= strap_cnt_reg;
    end
  end

  logic strap_grab;
  logic cfg_wr;

  assign strap_grab = strap_cnt_reg && !strap_done_reg;
  // writes after end of init are ignored; config is frozen
  assign cfg_wr     = apb_wr && paddr == FMPT_OFF_SYSCFG && !end_of_init_instr_done_reg && !strap_grab;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_enable_bit <= 1'b0;
    end else if (strap_grab) begin
      flash_enable_bit <= ~ea_sync_reg[1];
    end else if (cfg_wr) begin
      flash_enable_bit <= pwdata[FMPT_BIT_FLASH_EN];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_block_remap_bit <= FMPT_REMAP_RST;
    end else if (cfg_wr) begin
      low_block_remap_bit <= pwdata[FMPT_BIT_REMAP];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      segmentation_disable_bit <= FMPT_SEGDIS_RST;
    end else if (cfg_wr) begin
      segmentation_disable_bit <= pwdata[FMPT_BIT_SEGDIS];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      end_of_init_instr_done_reg <= 1'b0;
    end else if (cfg_wr) begin
      end_of_init_instr_done_reg <= pwdata[FMPT_BIT_END_OF_INIT_INSTR];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg <= 16'h0000;
    end else if (apb_wr && paddr == FMPT_OFF_CMD) begin
      cmd_reg <= pwdata[15:0];
    end
  end

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  logic [23:0] low_base;
  logic        acc_flash;
  logic        fetch_flash;

  function automatic logic in_flash(input logic [23:0] a, input logic [23:0] base, input logic en);
    logic lo;
    logic fx;
    lo = (a >= base) && (a < base + FMPT_LOW_SIZE);
    fx = (a >= FMPT_FIX_LO) && (a <= FMPT_FIX_HI);
    return en && (lo || fx);
  endfunction

  assign low_base    = low_block_remap_bit ? FMPT_LOW_SEG1 : FMPT_LOW_SEG0;
  assign acc_flash   = in_flash(mem_addr, low_base, flash_enable_bit);
  assign fetch_flash = in_flash(fetch_addr, low_base, flash_enable_bit);

  // ---------------------------------------------------------------
  // protection
  // ---------------------------------------------------------------
  logic prot_reg;
  logic unprot_wr;

  assign unprot_wr = mem_req && mem_write && acc_flash && !mem_addr[0]
                     && mem_wdata == 16'h0000 && fetch_flash;

  // a completion in the same cycle as a lift lets the otp value win
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot_reg <= 1'b1;
    end else if (strap_cnt_reg && !strap_done_reg) begin
      prot_reg <= otp_sync_reg[1];
    end else if (done_wr) begin
      prot_reg <= prot_reg | otp_sync_reg[1];
    end else if (unprot_wr) begin
      prot_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // trigger detector
  // ---------------------------------------------------------------
  fmpt_trig_t  trig_state;
  logic [23:0] trig_addr_reg;
  logic        trig_wr;

  assign trig_wr = mem_req && mem_write && acc_flash && !mem_addr[0] && !unprot_wr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_state    <= FMPT_IDLE;
      trig_addr_reg <= 24'h000000;
    end else begin
      case (trig_state)
        FMPT_IDLE: begin
          if (trig_wr && mem_direct) begin
            trig_state    <= FMPT_ARMED;
            trig_addr_reg <= mem_addr;
          end
        end
        FMPT_ARMED: begin
          if (mem_req) begin
            if (trig_wr && !mem_direct && mem_addr == trig_addr_reg) begin
              // a refused command never goes busy, else later triggers hang
              if (prot_reg) begin
                trig_state <= FMPT_IDLE;
              end else begin
                trig_state <= FMPT_RUN;
              end
            end else begin
              trig_state <= FMPT_IDLE;
            end
          end
        end
        FMPT_RUN: begin
          if (done_wr) begin
            trig_state <= FMPT_IDLE;
          end
        end
        default: trig_state <= FMPT_IDLE;
      endcase
    end
  end

  assign busy_reg = (trig_state == FMPT_RUN);

  logic fire;
  assign fire = (trig_state == FMPT_ARMED) && mem_req && trig_wr && !mem_direct
                && mem_addr == trig_addr_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_start <= 1'b0;
    end else begin
      // protected command: refused, reported, never launched
      cmd_start <= fire && !prot_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_code <= 16'h0000;
    end else if (fire) begin
      cmd_code <= cmd_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_reg <= FMPT_ERR_OK;
    end else if (fire) begin
      result_reg <= prot_reg ? FMPT_ERR_PROT : FMPT_ERR_OK;
    end
  end

  // ---------------------------------------------------------------
  // read path and status outputs
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_rdata <= 16'h0000;
    end else if (mem_req && !mem_write && acc_flash) begin
      // while protected, foreign code sees the dummy word, never the array
      mem_rdata <= (prot_reg && !fetch_flash) ? FMPT_DUMMY : flash_rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_hit_flash <= 1'b0;
    end else begin
      mem_hit_flash <= mem_req && acc_flash;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_block <= 1'b0;
    end else begin
      irq_block <= segment_override_prefix;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      protect_active <= 1'b1;
    end else begin
      protect_active <= prot_reg;
    end
  end

  // ---------------------------------------------------------------
  // apb slave: one wait-free access, pready high in the access phase only
  // ---------------------------------------------------------------
  logic [31:0] rd_word;
  logic        rd_bad;
  logic        wr_ok;

  // decode ahead of the flop so prdata stays a plain register output
  always_comb begin
    rd_word = 32'h00000000;
    rd_bad  = 1'b0;
    case (paddr)
      FMPT_OFF_SYSCFG: rd_word = {28'h0000000, end_of_init_instr_done_reg, segmentation_disable_bit,
                                  low_block_remap_bit, flash_enable_bit};
      FMPT_OFF_CMD:    rd_word = {16'h0000, cmd_reg};
      FMPT_OFF_STATUS: rd_word = {28'h0000000, strap_done_reg, busy_reg,
                                  (trig_state == FMPT_ARMED), prot_reg};
      FMPT_OFF_RESULT: rd_word = {24'h000000, result_reg};
      FMPT_OFF_DONE:   rd_word = 32'h00000000;
      default:         rd_bad  = 1'b1;
    endcase
  end

  assign wr_ok = (paddr == FMPT_OFF_SYSCFG) || (paddr == FMPT_OFF_CMD) || (paddr == FMPT_OFF_DONE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (apb_rd) begin
      prdata <= rd_word;
    end
  end

  // error flag rides with pready and drops in the cycle after
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= pwrite ? !wr_ok : rd_bad;
    end else begin
      pslverr <= 1'b0;
    end
  end

endmodule

// ---- fmpt_chk.sv ----
// fmpt_chk: port assertions for fmpt_top
// assumes a bind onto fmpt_top, one clock domain
`timescale 1ns/1ps
module fmpt_chk
  import fmpt_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        mem_req,
  input wire logic        mem_write,
  input wire logic        mem_direct,
  input wire logic [15:0] mem_wdata,
  input wire logic [23:0] fetch_addr,
  input wire logic        segment_override_prefix,
  input wire logic [15:0] flash_rdata,
  input wire logic [15:0] mem_rdata,
  input wire logic        mem_hit_flash,
  input wire logic        irq_block,
  input wire logic        cmd_start,
  input wire logic        protect_active
);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  wire rd_far  = mem_req && !mem_write && fetch_addr > FMPT_FIX_HI;
  wire rd_own  = mem_req && !mem_write && fetch_addr >= FMPT_FIX_LO && fetch_addr <= FMPT_FIX_HI;
  wire zero_wr = mem_req && mem_write && mem_wdata == 16'h0000 && fetch_addr <= FMPT_FIX_HI;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  irq_follow_a: assert property (irq_block == $past(segment_override_prefix))
    else $error("irq block off");
  start_second_a: assert property (cmd_start |-> $past(mem_req && mem_write && !mem_direct))
    else $error("start without indirect write");
  start_pulse_a: assert property (cmd_start |=> !cmd_start)
    else $error("start too long");
  start_unprot_a: assert property (cmd_start |-> !protect_active)
    else $error("start while protected");
  dummy_read_a: assert property ($past(rd_far) && mem_hit_flash && protect_active |-> mem_rdata == FMPT_DUMMY)
    else $error("no dummy word");
  own_read_a: assert property ($past(rd_own) && mem_hit_flash |-> mem_rdata == $past(flash_rdata))
    else $error("flash code read wrong");
  lift_cause_a: assert property ($fell(protect_active) && $past(presetn, 5) |-> $past(zero_wr, 2))
    else $error("lift without zero write");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  cover property (cmd_start);
  cover property ($fell(protect_active));
  cover property (mem_hit_flash && mem_rdata == FMPT_DUMMY);
endmodule

bind fmpt_top fmpt_chk chk (.pclk(pclk), .presetn(presetn), .pready(pready), .pslverr(pslverr),
  .mem_req(mem_req), .mem_write(mem_write), .mem_direct(mem_direct), .mem_wdata(mem_wdata),
  .fetch_addr(fetch_addr), .segment_override_prefix(segment_override_prefix), .flash_rdata(flash_rdata),
  .mem_rdata(mem_rdata), .mem_hit_flash(mem_hit_flash), .irq_block(irq_block), .cmd_start(cmd_start),
  .protect_active(protect_active));

// ---- fmpt_core.sv ----
// fmpt_core: behavioural core issuing memory accesses
// assumes fmpt_top memory port; tasks start and end on a rising edge
`timescale 1ns/1ps
module fmpt_core (
  input  wire logic        pclk,
  input  wire logic        cmd_start,
  input  wire logic [15:0] cmd_code,
  input  wire logic        mem_hit_flash,
  input  wire logic        irq_block,
  output logic             mem_req,
  output logic             mem_write,
  output logic             mem_direct,
  output logic      [23:0] mem_addr,
  output logic      [15:0] mem_wdata,
  output logic      [23:0] fetch_addr,
  output logic             segment_override_prefix,
  output logic      [15:0] flash_rdata
);
  logic        st_s, hit_s, blk_s;
  logic [15:0] code_s;
  initial {mem_req, mem_write, mem_direct, mem_addr, mem_wdata, fetch_addr, segment_override_prefix} = '0;
  // released bus shows the inverse so a stale word never passes
  assign flash_rdata = mem_req ? (mem_addr[15:0] ^ 16'h5a5a) : ~mem_addr[15:0];
  task automatic acc(input logic w, input logic d, input logic [23:0] a, input logic [15:0] wd,
                     input logic [23:0] f);
    @(posedge pclk);
    {mem_req, mem_write, mem_direct, mem_addr, mem_wdata, fetch_addr} <= {1'b1, w, d, a, wd, f};
    @(posedge pclk);
    {mem_req, mem_addr, mem_wdata} <= {1'b0, ~a, ~wd};
    // one-cycle outputs are read mid-cycle, while they stand
    @(negedge pclk);
    {st_s, code_s, hit_s, blk_s} = {cmd_start, cmd_code, mem_hit_flash, irq_block};
    @(posedge pclk);
  endtask
  task automatic trig(input logic [23:0] a, output logic st, output logic [15:0] code, output logic blk);
    segment_override_prefix <= 1'b1;
    acc(1'b1, 1'b1, a, a[15:0], 24'h200000);
    acc(1'b1, 1'b0, a, a[15:0], 24'h200000);
    {st, code, blk} = {st_s, code_s, blk_s};
    segment_override_prefix <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
endmodule

// ---- fmpt_top_tb.sv ----
// fmpt_top_tb: self-checking bench for fmpt_top
// assumes fmpt_core drives the memory port, the bench drives apb
`timescale 1ns/1ps
module fmpt_top_tb;
  import fmpt_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, er, st, ib, req, wr, dir, pfx, irq_blk, start, prot, hit;
  logic        ea_pin = 1'b0, otp_pin = 1'b1;
  logic [23:0] maddr, faddr;
  logic [15:0] wdata, frd, mrd, ccode, code;
  int          mismatches = 0, tests_run = 0;
  always #2.5 pclk = ~pclk;
  fmpt_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_access_pin(ea_pin), .otp_protect_bit(otp_pin), .mem_req(req), .mem_write(wr),
    .mem_direct(dir), .mem_addr(maddr), .mem_wdata(wdata), .fetch_addr(faddr),
    .segment_override_prefix(pfx), .flash_rdata(frd), .mem_rdata(mrd), .mem_hit_flash(hit),
    .irq_block(irq_blk), .cmd_start(start), .cmd_code(ccode), .protect_active(prot));
  fmpt_core core (.pclk(pclk), .cmd_start(start), .cmd_code(ccode), .mem_hit_flash(hit),
    .irq_block(irq_blk), .mem_req(req), .mem_write(wr),
    .mem_direct(dir), .mem_addr(maddr), .mem_wdata(wdata), .fetch_addr(faddr),
    .segment_override_prefix(pfx), .flash_rdata(frd));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic s_reset;
    repeat (8) @(posedge pclk);
    chk("prot_rst", 1, prot);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    apb(0, FMPT_OFF_SYSCFG, 0);
    chk("syscfg", 32'h5, rd);
    apb(0, FMPT_OFF_STATUS, 0);
    chk("status", 32'h9, rd);
    apb(0, 12'h020, 0);
    chk("unmapped", 32'h1, {rd[30:0], er});
  endtask
  task automatic s_restrap;
    {ea_pin, otp_pin} <= 2'b10;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    apb(0, FMPT_OFF_SYSCFG, 0);
    chk("syscfg_ext", 32'h4, rd);
    apb(0, FMPT_OFF_STATUS, 0);
    chk("status_open", 32'h8, rd);
  endtask
  task automatic s_protected;
    core.acc(0, 1, 24'h020000, 0, 24'h200000);
    chk("dummy", FMPT_DUMMY, mrd);
    core.acc(0, 1, 24'h020010, 0, 24'h020000);
    chk("own_read", 16'h0010 ^ 16'h5a5a, mrd);
    apb(1, FMPT_OFF_CMD, {FMPT_CMD_DWORD, 4'h1});
    core.trig(24'h018000, st, code, ib);
    chk("start_prot", 0, st);
    chk("prefix_on", 1, ib);
    chk("prefix_off", 0, irq_blk);
    apb(0, FMPT_OFF_RESULT, 0);
    chk("result_prot", FMPT_ERR_PROT, rd);
    core.acc(1, 1, 24'h018002, 0, 24'h200000);
    core.acc(0, 1, 24'h020000, 0, 24'h200000);
    apb(0, FMPT_OFF_STATUS, 0);
    chk("far_zero", 1, rd[0]);
  endtask
  task automatic s_lift;
    core.acc(1, 1, 24'h018004, 0, 24'h020000);
    apb(0, FMPT_OFF_STATUS, 0);
    chk("lifted", 0, rd[0]);
    core.acc(0, 1, 24'h020010, 0, 24'h200000);
    chk("far_read", 16'h0010 ^ 16'h5a5a, mrd);
  endtask
  task automatic s_cmd;
    logic [15:0] c [2];
    c = '{{FMPT_CMD_DWORD, 4'h1}, {FMPT_CMD_BLOCK, 4'h0}};
    for (int i = 0; i < 2; i++) begin
      apb(1, FMPT_OFF_CMD, {16'h0000, c[i]});
      core.trig(24'h018000, st, code, ib);
      chk("start", 1, st);
      chk("code", c[i], code);
      apb(0, FMPT_OFF_RESULT, 0);
      chk("result_ok", FMPT_ERR_OK, rd);
      apb(1, FMPT_OFF_DONE, 0);
      apb(0, FMPT_OFF_STATUS, 0);
      chk("rearm", 32'h9, rd);
      core.acc(1, 1, 24'h018004, 0, 24'h020000);
    end
  endtask
  task automatic s_disarm;
    for (int i = 0; i < 2; i++) begin
      core.acc(1, 1, 24'h018000, 16'h8000, 24'h200000);
      if (i == 0) core.acc(0, 1, 24'h020000, 0, 24'h200000);
      core.acc(1, 0, 24'h018000 + 24'(2 * i), 16'h8000, 24'h200000);
      chk("no_start", 0, core.st_s);
    end
  endtask
  task automatic s_map;
    logic [23:0] a [6];
    logic [1:0]  cf [6];
    logic [5:0]  ex;
    a = '{24'h000100, 24'h010100, 24'h000100, 24'h010100, 24'h04fffe, 24'h018000};
    cf = '{2'h1, 2'h1, 2'h3, 2'h3, 2'h3, 2'h2};
    ex = 6'b011001;
    for (int i = 0; i < 6; i++) begin
      apb(1, FMPT_OFF_SYSCFG, {30'h0, cf[i]});
      core.acc(0, 1, a[i], 0, 24'h200000);
      chk("hit", ex[i], core.hit_s);
    end
  endtask
  initial begin
    s_reset;
    s_protected;
    s_lift;
    s_cmd;
    s_disarm;
    s_map;
    s_restrap;
    test_done;
  end
  initial begin
    #20000;
    mismatches++;
    test_done;
  end
endmodule
